// ---- common/pmsc_pkg.sv ----
// Constants shared by the module end and the host end of the sideband.
// Assumes both ends meet through pmsc_if; module end runs on the link clock.
package pmsc_pkg;
    // Least module reset pulse, in link clock cycles
    localparam int RESET_MIN_CYC = 4;
    // Initialisation time after reset, in link clock cycles
    localparam int INIT_CYC = 16;
    // Host clock divider for the link clock (half period)
    localparam int LINK_DIV = 4;
    // Host reset pulse length, in host clock cycles
    localparam int HOST_RST_CYC = 64;
    // Counter width
    localparam int CNT_W = 8;
    // Power levels
    localparam logic [1:0] POWER_LOW = 2'h1;
    localparam logic [1:0] POWER_HIGH = 2'h3;
endpackage

// ---- common/pmsc_if.sv ----
// Sideband wires between one pluggable module and its host.
// Assumes open-drain interrupt and presence are resolved here with pull-ups.
`timescale 1ns/1ps
interface pmsc_if;
    logic linkClk;          // Link clock, made by host
    logic moduleSelectN;    // Host select, low active
    logic moduleResetN;     // Host reset, low active
    logic lowPowerSelect;   // Low power request
    logic intOe;            // Module pulls interrupt low
    logic presOe;           // Module grounds presence
    logic moduleInterruptN; // Resolved interrupt line
    logic modulePresentN;   // Resolved presence line
    logic busReq;           // Two-wire request stand-in
    logic busAck;           // Module answer
    logic notReady;         // Not-ready flag from map
    // Host pull-ups on open-drain lines
    assign moduleInterruptN = ~intOe;
    assign modulePresentN = ~presOe;
    modport device (input linkClk, moduleSelectN, moduleResetN, lowPowerSelect, busReq,
        output intOe, presOe, busAck, notReady);
    modport host (output linkClk, moduleSelectN, moduleResetN, lowPowerSelect, busReq,
        input moduleInterruptN, modulePresentN, busAck, notReady);
endinterface

// ---- src/pmsc_device.sv ----
// Module end: reset, readiness, interrupt, select gating, power cap.
// Assumes link clock from host; user side runs on clk with sync reset.
`timescale 1ns/1ps
module pmsc_device import pmsc_pkg::*; (
    // Link side
    pmsc_if.device link,
    // User side
    input wire logic clk,
    input wire logic nrst,
    input wire logic faultEvent,
    output logic [1:0] powerLimit,
    output logic ready
);

    // Power-on request, user side; stands until the link side echoes it.
    // A plain synchronised reset would never arrive, since the host keeps
    // the link clock still while its own reset is applied.
    logic porReq_ff;

    // Echo of the power-on request, back on clk
    logic porAckS1_ff; // First flop
    logic porAckS2_ff; // Second flop, the only one read

    // Power-on request on the link clock
    logic porS1_ff; // First flop
    logic porS2_ff; // Second flop, holds the link side in reset
    logic porAck_ff; // Echo towards the user side

    // Host pins, two flops each before any logic reads them
    logic selS1_ff; // Select, first flop
    logic selS2_ff; // Select, low while chosen
    logic rstS1_ff; // Reset pin, first flop
    logic rstS2_ff; // Reset pin, low while applied
    logic reqS1_ff; // Bus request, first flop
    logic reqS2_ff; // Bus request, usable

    // Reset pulse length, saturating at the least pulse
    logic [CNT_W-1:0] rstCnt_ff;

    // Initialisation progress after power-up or a long reset pulse
    logic [CNT_W-1:0] initCnt_ff;

    // Map flag and line state
    logic notReady_ff; // Not-ready flag, high until init done
    logic intPend_ff; // Interrupt owed to the host
    logic busAck_ff; // Answer to a selected request

    // Fault event, carried across as a toggle
    logic faultTog_ff; // User side toggle
    logic faultTogL1_ff; // Link side, first flop
    logic faultTogL2_ff; // Link side, second flop
    logic faultSeen_ff; // Last toggle value acted on

    // Readiness and low-power pin on clk
    logic doneSync1_ff; // Done level, first flop
    logic doneSync2_ff; // Done level, drives ready
    logic lpS1_ff; // Low-power pin, first flop
    logic lpS2_ff; // Low-power pin, usable

    // Decoded link side conditions
    logic porHold; // Power-on reset still applied
    logic longReset; // Reset pin low past the least pulse
    logic faultNew; // Fresh fault toggle arrived
    logic readStart; // First cycle of a selected request

    // Power-on request: raised by the user reset, dropped once echoed.
    // Four-phase, so the request is never lost however slow the link clock.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            // Power-up or hot insertion
            porReq_ff <= 1'b1;
        end else if (porAckS2_ff) begin
            // Link side has seen it
            porReq_ff <= 1'b0;
        end
    end

    // Echo of the link side back onto clk
    always_ff @(posedge clk) begin
        if (!nrst) begin
            porAckS1_ff <= 1'b0;
            porAckS2_ff <= 1'b0;
        end else begin
            porAckS1_ff <= porAck_ff;
            porAckS2_ff <= porAckS1_ff;
        end
    end

    // Power-on request onto the link clock, then echoed.
    // No reset here: these flops are the reset of the link side.
    always_ff @(posedge link.linkClk) begin
        porS1_ff <= porReq_ff;
        porS2_ff <= porS1_ff;
        porAck_ff <= porS2_ff;
    end

    // Host pins; they change on the host clock, so treat them as foreign
    always_ff @(posedge link.linkClk) begin
        selS1_ff <= link.moduleSelectN;
        selS2_ff <= selS1_ff;
        rstS1_ff <= link.moduleResetN;
        rstS2_ff <= rstS1_ff;
        reqS1_ff <= link.busReq;
        reqS2_ff <= reqS1_ff;
    end

    // Fault toggle from the user side; only the second flop is read
    always_ff @(posedge link.linkClk) begin
        faultTogL1_ff <= faultTog_ff;
        faultTogL2_ff <= faultTogL1_ff;
        faultSeen_ff <= faultTogL2_ff;
    end

    // Link side conditions used by several processes
    assign porHold = porS2_ff;
    assign longReset = !rstS2_ff && (rstCnt_ff >= CNT_W'(RESET_MIN_CYC));
    assign faultNew = faultSeen_ff != faultTogL2_ff;
    // Selected only; a request while deselected is ignored
    assign readStart = reqS2_ff && !selS2_ff && !busAck_ff;

    // Reset pulse length; short glitches on the pin never reach the count end
    always_ff @(posedge link.linkClk) begin
        if (porHold || rstS2_ff) begin
            // Pin released or still powering up
            rstCnt_ff <= '0;
        end else if (rstCnt_ff < CNT_W'(RESET_MIN_CYC)) begin
            // Pin low, still short of the least pulse
            rstCnt_ff <= rstCnt_ff + 1'b1;
        end
    end

    // Initialisation after power-up or a long reset pulse.
    // The count is held at zero for as long as the reset stands.
    always_ff @(posedge link.linkClk) begin
        if (porHold || longReset) begin
            // Full reset: every setting back to default
            initCnt_ff <= '0;
            notReady_ff <= 1'b1;
        end else if (initCnt_ff < CNT_W'(INIT_CYC)) begin
            // Initialisation running
            initCnt_ff <= initCnt_ff + 1'b1;
            notReady_ff <= 1'b1;
        end else begin
            // Done; flag drops in the same cycle the interrupt is raised
            notReady_ff <= 1'b0;
        end
    end

    // Interrupt owed to the host.
    // Set wins over the read clear, so an event meeting a read is not lost.
    always_ff @(posedge link.linkClk) begin
        if (porHold || longReset) begin
            // Reset drops any pending cause
            intPend_ff <= 1'b0;
        end else if (notReady_ff && initCnt_ff == CNT_W'(INIT_CYC)) begin
            // Completion of reset or power-up
            intPend_ff <= 1'b1;
        end else if (faultNew) begin
            // Fault or critical status
            intPend_ff <= 1'b1;
        end else if (readStart && !notReady_ff) begin
            // Host has read the status
            intPend_ff <= 1'b0;
        end
    end

    // Bus answer; registered, so it falls only after the request falls
    always_ff @(posedge link.linkClk) begin
        if (porHold) begin
            busAck_ff <= 1'b0;
        end else begin
            // Answer only while the host selects this module
            busAck_ff <= reqS2_ff && !selS2_ff;
        end
    end

    // Interrupt only pulls low; the host resistor gives the high level
    assign link.intOe = intPend_ff;
    // Inserted module always grounds the presence line
    assign link.presOe = 1'b1;
    assign link.busAck = busAck_ff;
    assign link.notReady = notReady_ff;

    // User side fault event, turned into a toggle for the crossing.
    // Limitation: an even number of events within one link cycle cancel out and are not seen.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            faultTog_ff <= 1'b0;
        end else if (faultEvent) begin
            faultTog_ff <= ~faultTog_ff;
        end
    end

    // Ready level and power pin synchronised onto clk.
    // Power pin resets to low power, the safe side for a hot host.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            doneSync1_ff <= 1'b0;
            doneSync2_ff <= 1'b0;
            lpS1_ff <= 1'b1;
            lpS2_ff <= 1'b1;
        end else begin
            doneSync1_ff <= ~notReady_ff;
            doneSync2_ff <= doneSync1_ff;
            lpS1_ff <= link.lowPowerSelect;
            lpS2_ff <= lpS1_ff;
        end
    end

    // Power cap output, from a flop
    always_ff @(posedge clk) begin
        if (!nrst) begin
            // Low cap until the pin is known
            powerLimit <= POWER_LOW;
        end else begin
            // Pin high caps the draw
            powerLimit <= lpS2_ff ? POWER_LOW : POWER_HIGH;
        end
    end

    // Ready straight from the second flop
    assign ready = doneSync2_ff;

endmodule // pmsc_device

// ---- src/pmsc_host.sv ----
// Host end: divides link clock, drives select, reset and power pins.
// Assumes one module per select line; sync reset on clk.
`timescale 1ns/1ps
module pmsc_host import pmsc_pkg::*; (
    // Link side
    pmsc_if.host link,
    // User side
    input wire logic clk,
    input wire logic nrst,
    input wire logic resetReq,
    input wire logic lowPower,
    input wire logic readReq,
    output logic statusValid,
    output logic present,
    output logic intSeen
);
    logic [CNT_W-1:0] div_ff;
    logic linkClk_ff;
    logic [CNT_W-1:0] rstCnt_ff;
    logic i1_ff, i2_ff, p1_ff, p2_ff;
    logic nr1_ff; // Not-ready flag, first flop
    logic nr2_ff; // Not-ready flag, usable
    logic a1_ff; // Bus answer, first flop
    logic a2_ff; // Bus answer, usable
    logic resetN_ff; // Reset pin drive
    logic sel_ff; // Select, high while chosen
    logic req_ff; // Request, held until answered
    logic statusValid_ff; // Status may be trusted
    // Link clock divider
    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_ff <= '0;
            linkClk_ff <= 1'b0;
        end else if (div_ff == CNT_W'(LINK_DIV - 1)) begin
            div_ff <= '0;
            linkClk_ff <= ~linkClk_ff;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end
    // Reset pulse longer than least length
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rstCnt_ff <= '0;
        end else if (resetReq) begin
            rstCnt_ff <= CNT_W'(HOST_RST_CYC);
        end else if (rstCnt_ff != '0) begin
            rstCnt_ff <= rstCnt_ff - 1'b1;
        end
    end
    // Reset pin from a flop; falls with the request itself
    always_ff @(posedge clk) begin
        if (!nrst) begin
            resetN_ff <= 1'b1;
        end else begin
            resetN_ff <= (rstCnt_ff == '0) && !resetReq;
        end
    end
    // Pin sync, idle levels after reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            {i1_ff, i2_ff, p1_ff, p2_ff} <= 4'hf;
            nr1_ff <= 1'b1;
            nr2_ff <= 1'b1;
            a1_ff <= 1'b0;
            a2_ff <= 1'b0;
        end else begin
            i1_ff <= link.moduleInterruptN;
            i2_ff <= i1_ff;
            p1_ff <= link.modulePresentN;
            p2_ff <= p1_ff;
            nr1_ff <= link.notReady;
            nr2_ff <= nr1_ff;
            a1_ff <= link.busAck;
            a2_ff <= a1_ff;
        end
    end
    // Status read: request holds until answered, select until answer is gone
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sel_ff <= 1'b0;
            req_ff <= 1'b0;
        end else if (!sel_ff) begin
            if (readReq && !i2_ff) begin
                sel_ff <= 1'b1;
                req_ff <= 1'b1;
            end
        end else if (req_ff) begin
            if (a2_ff) begin
                req_ff <= 1'b0;
            end
        end else if (!a2_ff) begin
            sel_ff <= 1'b0;
        end
    end
    // Status trusted only after the completion interrupt with flag clear
    always_ff @(posedge clk) begin
        if (!nrst || resetReq) begin
            statusValid_ff <= 1'b0;
        end else if (rstCnt_ff == '0 && !i2_ff && !nr2_ff) begin
            statusValid_ff <= 1'b1;
        end
    end
    assign link.linkClk = linkClk_ff;
    assign link.moduleResetN = resetN_ff;
    assign link.moduleSelectN = ~sel_ff;
    assign link.lowPowerSelect = lowPower;
    assign link.busReq = req_ff;
    assign statusValid = statusValid_ff;
    assign present = ~p2_ff;
    assign intSeen = ~i2_ff;
endmodule // pmsc_host

// ---- test/pmsc_sva.sv ----
// Checker on the sideband wires between module and host ends.
// Assumes the bench places it beside the joining interface.
`timescale 1ns/1ps
module pmsc_sva (
    // Link wires
    input wire logic linkClk,
    input wire logic moduleSelectN,
    input wire logic moduleResetN,
    input wire logic intOe,
    input wire logic modulePresentN,
    input wire logic busReq,
    input wire logic busAck,
    input wire logic notReady
);
    // Link domain; module reset wire is its reset
    default clocking @(posedge linkClk); endclocking
    property p_sel; busAck |-> !moduleSelectN; endproperty
    a_sel: assert property (p_sel) else $error("ack while deselected");
    property p_bus; disable iff (!moduleResetN)
        busReq && !moduleSelectN && !notReady |-> ##[1:4] busAck; endproperty
    a_bus: assert property (p_bus) else $error("selected request unanswered");
    property p_rnr; !moduleResetN [*5] |-> ##[1:4] notReady; endproperty
    a_rnr: assert property (p_rnr) else $error("ready during reset");
    property p_rint; !moduleResetN [*5] |-> ##[1:4] !intOe; endproperty
    a_rint: assert property (p_rint) else $error("interrupt kept over reset");
    property p_init; $rose(moduleResetN) && notReady |->
        notReady [*8] ##[1:24] !notReady; endproperty
    a_init: assert property (p_init) else $error("init length wrong");
    property p_done; disable iff (!moduleResetN) $fell(notReady) |-> ##[0:2] intOe; endproperty
    a_done: assert property (p_done) else $error("no completion interrupt");
    property p_hold; disable iff (!moduleResetN)
        intOe && !(busReq && !moduleSelectN) |=> intOe; endproperty
    a_hold: assert property (p_hold) else $error("interrupt dropped unread");
    property p_pres; disable iff (!moduleResetN) !modulePresentN; endproperty
    a_pres: assert property (p_pres) else $error("presence not grounded");
    // Main scenarios
    c_rst: cover property ($rose(moduleResetN));
    c_int: cover property ($rose(intOe));
    c_ack: cover property (busAck);
endmodule // pmsc_sva

// ---- test/pluggable_module_sideband_control_tb.sv ----
// Bench joining module and host ends across the sideband wires.
// Assumes the host end divides clk down to make the link clock.
`timescale 1ns/1ps
module pluggable_module_sideband_control_tb;
    import pmsc_pkg::*;
    logic clk, nrst, resetReq, lowPower, readReq, faultEvent; // Bench inputs
    logic statusValid, present, intSeen, ready; // Observed flags
    logic [1:0] powerLimit; // Power cap seen
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0; // Hang guard
    pmsc_if pmsc_if_i ();
    pmsc_host pmsc_host_i (.link(pmsc_if_i), .clk(clk), .nrst(nrst), .resetReq(resetReq),
        .lowPower(lowPower), .readReq(readReq), .statusValid(statusValid),
        .present(present), .intSeen(intSeen));
    pmsc_device pmsc_device_i (.link(pmsc_if_i), .clk(clk), .nrst(nrst),
        .faultEvent(faultEvent), .powerLimit(powerLimit), .ready(ready));
    pmsc_sva pmsc_sva_i (.linkClk(pmsc_if_i.linkClk), .moduleSelectN(pmsc_if_i.moduleSelectN),
        .moduleResetN(pmsc_if_i.moduleResetN), .intOe(pmsc_if_i.intOe),
        .modulePresentN(pmsc_if_i.modulePresentN), .busReq(pmsc_if_i.busReq),
        .busAck(pmsc_if_i.busAck), .notReady(pmsc_if_i.notReady));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Ceiling well above the planned run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic pause(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        pause(1);
        s = 1'b0;
    endtask
    task automatic cmp1(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic cmp2(input string what, input logic [1:0] exp, input logic [1:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Power-up, power cap, read, fault, then host reset
    initial begin
        {nrst, resetReq, lowPower, readReq, faultEvent} = 5'h00;
        pause(8);
        nrst = 1'b1;
        pause(400);
        cmp1("present", 1'b1, present);
        cmp1("ready", 1'b1, ready);
        cmp1("intSeen", 1'b1, intSeen);
        cmp1("statusValid", 1'b1, statusValid);
        cmp2("powerLimit", POWER_HIGH, powerLimit);
        $display("Test powerup done");
        lowPower = 1'b1;
        pause(100);
        cmp2("powerLimit", POWER_LOW, powerLimit);
        pulse(readReq);
        pause(100);
        cmp1("statusValid", 1'b1, statusValid);
        cmp1("intSeen", 1'b0, intSeen);
        pulse(faultEvent);
        pause(100);
        cmp1("intSeen", 1'b1, intSeen);
        $display("Test power and fault done");
        pulse(resetReq);
        pause(120);
        cmp1("ready", 1'b0, ready);
        cmp1("intSeen", 1'b0, intSeen);
        cmp1("statusValid", 1'b0, statusValid);
        pause(400);
        cmp1("ready", 1'b1, ready);
        cmp1("intSeen", 1'b1, intSeen);
        cmp1("statusValid", 1'b1, statusValid);
        $display("Test reset done");
        finish_test();
    end
endmodule // pluggable_module_sideband_control_tb
